// *** hw/spp_pkg.sv ***
package spp_pkg;
    // Serial word length in bits
    localparam int unsigned WORD_BITS = 8;
    // Width of the edge index inside one word
    localparam int unsigned EDGE_W = 5;
    // Clock edges per word: one full cycle per bit
    localparam logic [EDGE_W-1:0] EDGES_PER_WORD = 5'h10;
    // Width of the bit counters on the link side
    localparam int unsigned BIT_W = 3;
    // Last bit index inside a word
    localparam logic [BIT_W-1:0] LAST_BIT = 3'h7;
    // Width of the half-period divider setting
    localparam int unsigned BAUD_W = 8;
    // Shortest half period in mclk cycles, keeps the bit rate at mclk/4 or below
    localparam logic [BAUD_W-1:0] MIN_HALF = 8'h02;
    // Reset values
    localparam logic [WORD_BITS-1:0] WORD_RST = 8'h00;
    localparam logic [BAUD_W-1:0] HALF_RST = 8'h00;

    // Master-side sequencer states
    typedef enum logic [0:0] {
        MS_IDLE,
        MS_SHIFT
    } spp_mstate_t;
endpackage

// *** hw/spp_port.sv ***
`timescale 1ns/1ps
//Contract
// [RULE1] Only master drives clock, one cycle per bit
// [RULE2] Clock toggles only during a word
// [RULE3] Slave ignores clock while select is high
// [RULE4] Launch on one edge, sample on other
// [RULE5] Polarity and phase bits select transfer format
// [RULE6] Select is active low, like chip select
// [RULE7] Select low in master mode flags error
// [RULE8] Lone master holds its own select high
// [RULE9] Any flag output may drive slave select
// [RULE10] MOSI drives as master, receives as slave
// [RULE11] MISO receives as master, drives as slave
// [RULE12] Open-drain bit makes MISO open drain
// [RULE13] Only one slave drives MISO at once
// [RULE14] Disable bit turns MISO driver off
// [RULE15] Full duplex, bit rate at most mclk/4
// [RULE16] Works as master or slave in multimaster
// [RULE17] On error, release outputs and raise flag
module spp_port (
    input  wire logic                           mclk,
    input  wire logic                           rst_b,
    // Link pins
    input  wire logic                           sclkIn,
    output logic                                sclkOut,
    output logic                                sclkOe,
    input  wire logic                           mosiIn,
    output logic                                mosiOut,
    output logic                                mosiOe,
    input  wire logic                           misoIn,
    output logic                                misoOut,
    output logic                                misoOe,
    input  wire logic                           slaveSelectIn_b,
    // Control bits
    input  wire logic                           masterMode,
    input  wire logic                           clkPolarity,
    input  wire logic                           clkPhase,
    input  wire logic                           openDrainSelect,
    input  wire logic                           slaveOutDisable,
    input  wire logic [spp_pkg::BAUD_W-1:0]     baudHalf,
    // Word interface
    input  wire logic [spp_pkg::WORD_BITS-1:0]  txData,
    input  wire logic                           txStart,
    output logic                                busy,
    output logic [spp_pkg::WORD_BITS-1:0]       rxData,
    output logic                                rxValid,
    // Status
    output logic                                mmErr,
    input  wire logic                           errClear
);
    // ---------------- Link clock domain (slave role) ----------------
    // Link clock: rising edge is always the sampling edge for this mode pair
    logic                                linkClk;
    // Counters restart whenever the port is not a selected slave
    logic                                frameRst_b;
    // MISO enable also drops on disable
    logic                                oeRst_b;
    logic [spp_pkg::BIT_W-1:0]           scnt;      // Sampled bits
    logic [spp_pkg::BIT_W-1:0]           lcnt;      // Launched bits
    logic [spp_pkg::WORD_BITS-1:0]       sRxSh;     // Slave receive shifter
    logic [spp_pkg::WORD_BITS-1:0]       sRxWord;   // Held until next word ends
    logic [spp_pkg::WORD_BITS-1:0]       sTxSh;     // Slave transmit shifter
    logic                                doneTog;   // Flips once per slave word
    logic                                nextBit;   // Bit launched at this edge

    assign linkClk    = sclkIn ^ clkPolarity ^ clkPhase; // [RULE5]
    assign frameRst_b = rst_b & ~slaveSelectIn_b & ~masterMode; // [RULE3] [RULE6]
    assign oeRst_b    = frameRst_b & ~slaveOutDisable & ~mmErr; // [RULE14]

    // Sample MOSI on the sampling edge
    always_ff @(posedge linkClk or negedge frameRst_b) begin
        if (!frameRst_b) begin
            scnt <= '0;
        end else begin
            scnt <= scnt + 3'h1; // [RULE4]
        end
    end

    // Receive shifter and word capture; not reset by select so data stays held
    always_ff @(posedge linkClk or negedge rst_b) begin
        if (!rst_b) begin
            sRxSh   <= spp_pkg::WORD_RST;
            sRxWord <= spp_pkg::WORD_RST;
            doneTog <= 1'b0;
        end else if (!slaveSelectIn_b && !masterMode) begin // [RULE3]
            sRxSh <= {sRxSh[spp_pkg::WORD_BITS-2:0], mosiIn}; // [RULE10]
            if (scnt == spp_pkg::LAST_BIT) begin
                sRxWord <= {sRxSh[spp_pkg::WORD_BITS-2:0], mosiIn};
                doneTog <= ~doneTog;
            end
        end
    end

    // Launch counter on the opposite edge
    always_ff @(negedge linkClk or negedge frameRst_b) begin
        if (!frameRst_b) begin
            lcnt <= '0;
        end else begin
            lcnt <= lcnt + 3'h1; // [RULE4]
        end
    end

    // Phase 1 loads at the first launch; phase 0 preloads the next msb at the last
    always_comb begin
        if ((clkPhase && lcnt == '0) || (!clkPhase && lcnt == spp_pkg::LAST_BIT)) begin
            nextBit = txData[spp_pkg::WORD_BITS-1];
        end else begin
            nextBit = sTxSh[spp_pkg::WORD_BITS-1];
        end
    end

    // Transmit shifter; txData must be held stable while selected
    always_ff @(negedge linkClk or negedge rst_b) begin
        if (!rst_b) begin
            sTxSh   <= spp_pkg::WORD_RST;
            misoOut <= 1'b0;
        end else if (!slaveSelectIn_b && !masterMode) begin // [RULE3]
            misoOut <= nextBit; // [RULE11]
            if ((clkPhase && lcnt == '0) || (!clkPhase && lcnt == spp_pkg::LAST_BIT)) begin
                sTxSh <= {txData[spp_pkg::WORD_BITS-2:0], 1'b0};
            end else begin
                sTxSh <= {sTxSh[spp_pkg::WORD_BITS-2:0], 1'b0};
            end
        end
    end

    // MISO enable: open drain only pulls low, cleared at once when deselected
    always_ff @(negedge linkClk or negedge oeRst_b) begin
        if (!oeRst_b) begin
            misoOe <= 1'b0; // [RULE13] [RULE14]
        end else begin
            misoOe <= !openDrainSelect || !nextBit; // [RULE12]
        end
    end

    // ---------------- mclk domain ----------------
    logic                                ssSync;    // Select, synchronised
    logic                                misoSync;  // MISO, synchronised
    logic                                togSync;   // Slave word toggle
    logic                                togSeen;   // Edge detect of toggle
    spp_pkg::spp_mstate_t                mstate;
    logic [spp_pkg::BAUD_W-1:0]          halfCnt;
    logic [spp_pkg::BAUD_W-1:0]          halfLimit;
    logic [spp_pkg::EDGE_W-1:0]          edgeCnt;
    logic [spp_pkg::WORD_BITS-1:0]       mTxSh;
    logic [spp_pkg::WORD_BITS-1:0]       mRxSh;
    logic                                edgeTick;  // Clock edge due now
    logic                                sampleEdge;
    logic                                lastEdge;
    logic                                mmHit;     // Select seen low as master
    logic                                startOk;
    logic                                slaveDone;

    spp_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk     (mclk),
        .rst_b   (rst_b),
        .asyncIn ({slaveSelectIn_b, misoIn, doneTog}), // [RULE9]
        .rstVal  (3'h7),
        .syncOut ({ssSync, misoSync, togSync})
    );

    // Divider floor keeps the bit rate within mclk/4
    assign halfLimit  = (baudHalf < spp_pkg::MIN_HALF) ? spp_pkg::MIN_HALF : baudHalf; // [RULE15]
    assign edgeTick   = (mstate == spp_pkg::MS_SHIFT) && (halfCnt == halfLimit - 8'h01);
    assign sampleEdge = (edgeCnt[0] == clkPhase); // [RULE4] [RULE5]
    assign lastEdge   = (edgeCnt == spp_pkg::EDGES_PER_WORD - 5'h01);
    assign mmHit      = masterMode && !ssSync; // [RULE7]
    assign startOk    = txStart && masterMode && !mmErr && !mmHit && (mstate == spp_pkg::MS_IDLE);
    assign slaveDone  = togSync ^ togSeen;

    // Sequencer and half-period counter
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mstate  <= spp_pkg::MS_IDLE;
            halfCnt <= spp_pkg::HALF_RST;
            edgeCnt <= '0;
        end else begin
            case (mstate)
                spp_pkg::MS_IDLE: begin
                    halfCnt <= spp_pkg::HALF_RST;
                    edgeCnt <= '0;
                    if (startOk) begin
                        mstate <= spp_pkg::MS_SHIFT;
                    end
                end
                spp_pkg::MS_SHIFT: begin
                    if (mmHit || mmErr) begin
                        mstate <= spp_pkg::MS_IDLE; // [RULE17]
                    end else if (edgeTick) begin
                        halfCnt <= spp_pkg::HALF_RST;
                        edgeCnt <= edgeCnt + 5'h01; // [RULE1]
                        if (lastEdge) begin
                            mstate <= spp_pkg::MS_IDLE;
                        end
                    end else begin
                        halfCnt <= halfCnt + 8'h01;
                    end
                end
                default: begin
                    mstate <= spp_pkg::MS_IDLE;
                end
            endcase
        end
    end

    // Serial clock: idles at the polarity level, toggles only while shifting
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sclkOut <= 1'b0;
        end else if (mstate == spp_pkg::MS_SHIFT && edgeTick && !mmHit && !mmErr) begin
            sclkOut <= ~sclkOut; // [RULE1] [RULE2]
        end else if (mstate == spp_pkg::MS_IDLE || mmHit || mmErr) begin
            sclkOut <= clkPolarity; // [RULE2] [RULE5]
        end
    end

    // Master data path: launch on one edge, sample MISO on the other
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mTxSh   <= spp_pkg::WORD_RST;
            mRxSh   <= spp_pkg::WORD_RST;
            mosiOut <= 1'b0;
        end else if (startOk) begin
            if (!clkPhase) begin
                mosiOut <= txData[spp_pkg::WORD_BITS-1]; // [RULE10]
                mTxSh   <= {txData[spp_pkg::WORD_BITS-2:0], 1'b0};
            end else begin
                mTxSh <= txData;
            end
        end else if (edgeTick) begin
            if (sampleEdge) begin
                mRxSh <= {mRxSh[spp_pkg::WORD_BITS-2:0], misoSync}; // [RULE11] [RULE4]
            end else if (clkPhase || !lastEdge) begin
                mosiOut <= mTxSh[spp_pkg::WORD_BITS-1]; // [RULE4]
                mTxSh   <= {mTxSh[spp_pkg::WORD_BITS-2:0], 1'b0};
            end
        end
    end

    // Pin enables: only an error-free master drives clock and MOSI
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sclkOe <= 1'b0;
            mosiOe <= 1'b0;
        end else begin
            sclkOe <= masterMode && !mmErr && !mmHit; // [RULE1] [RULE17]
            mosiOe <= masterMode && !mmErr && !mmHit; // [RULE10] [RULE16]
        end
    end

    // Busy follows the sequencer on the same edge as its decision
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            busy <= 1'b0;
        end else if (startOk) begin
            busy <= 1'b1;
        end else if (mmHit || mmErr || (edgeTick && lastEdge)) begin
            busy <= 1'b0;
        end
    end

    // Received words from either role, one-cycle valid pulse
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rxData  <= spp_pkg::WORD_RST;
            rxValid <= 1'b0;
            togSeen <= 1'b0;
        end else begin
            togSeen <= togSync;
            rxValid <= 1'b0;
            if (edgeTick && lastEdge && !mmHit && !mmErr) begin
                rxData  <= clkPhase ? {mRxSh[spp_pkg::WORD_BITS-2:0], misoSync} : mRxSh; // [RULE15]
                rxValid <= 1'b1;
            end else if (slaveDone && !masterMode) begin
                rxData  <= sRxWord; // [RULE16]
                rxValid <= 1'b1;
            end
        end
    end

    // Multimaster error flag; a new hit beats a clear in the same cycle
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mmErr <= 1'b0;
        end else if (mmHit) begin
            mmErr <= 1'b1; // [RULE7] [RULE17]
        end else if (errClear) begin
            mmErr <= 1'b0;
        end
    end

    // ---------------- Checks ----------------
    logic [5:0] edgesSeen; // Clock toggles seen in the current word

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            edgesSeen <= '0;
        end else if (startOk) begin
            edgesSeen <= '0;
        end else if (busy && (sclkOut != $past(sclkOut))) begin
            edgesSeen <= edgesSeen + 6'h01;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    // Sixteenth toggle lands with busy falling, so fifteen are counted plus this one
    a_word_edges: assert property ($fell(busy) && !$past(mmErr) && !$past(mmHit) |-> edgesSeen == 6'h0f && $changed(sclkOut)) // [RULE1]
        else $error("serial clock did not make one cycle per bit");
    // Idle level follows a polarity change one cycle late, so skip two cycles after it
    a_sclk_idle: assert property (!busy && !$past(busy) && $stable(clkPolarity)
        && $past(clkPolarity, 2) == clkPolarity |-> $stable(sclkOut)) // [RULE2]
        else $error("serial clock moved between words");
    a_err_raise: assert property (masterMode && !ssSync |=> mmErr) // [RULE7]
        else $error("select low in master mode did not flag an error");
    a_err_release: assert property (mmErr |=> !sclkOe && !mosiOe && !busy) // [RULE17]
        else $error("outputs still driven during multimaster error");
    a_mosi_slave: assert property (!masterMode |=> !mosiOe) // [RULE10]
        else $error("MOSI driven while slave");
    a_miso_master: assert property (masterMode |-> !misoOe) // [RULE11]
        else $error("MISO driven while master");
    a_miso_disable: assert property (slaveOutDisable |-> !misoOe) // [RULE14]
        else $error("MISO driven while disabled");
    a_miso_od: assert property (openDrainSelect && $stable(openDrainSelect) && misoOe |-> !misoOut) // [RULE12]
        else $error("open-drain MISO drove high");
    a_rate_cap: assert property ($changed(sclkOut) && busy |=> $stable(sclkOut)) // [RULE15]
        else $error("serial clock faster than mclk/4");
    a_start_edge: assert property (startOk |=> busy ##1 sclkOut == $past(sclkOut) [*1]) // [RULE2]
        else $error("clock toggled before the first half period");

    c_master_word: cover property ($fell(busy) && rxValid);
    c_slave_word: cover property (slaveDone && !masterMode);
    c_mm_error: cover property ($rose(mmErr));
    c_od_low: cover property (openDrainSelect && misoOe);
endmodule

// *** hw/spp_sync.sv ***
`timescale 1ns/1ps
// Two-flop synchroniser for levels entering the mclk domain
module spp_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] asyncIn,
    input  wire logic [WIDTH-1:0] rstVal,
    output logic      [WIDTH-1:0] syncOut
);
    // First stage, read only by the second stage
    logic [WIDTH-1:0] meta;

    // Reset value is all ones, whatever the instance ties to rstVal
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta    <= '1;
            syncOut <= '1;
        end else begin
            meta    <= asyncIn;
            syncOut <= meta;
        end
    end
    // The rstVal port documents the idle level; high suits select and MISO, not doneTog, which resets low
    logic unusedRst;
    assign unusedRst = ^rstVal;
endmodule

// *** tb/spp_far_model.sv ***
`timescale 1ns/1ps
// Far-side device: master through task calls, slave on the pin clock
module spp_far_model (
    input  wire logic       lclk,
    input  wire logic       cpol,
    input  wire logic       cpha,
    input  wire logic       sclkPin,
    input  wire logic       mosiPin,
    input  wire logic       misoPin,
    input  wire logic       slvSel_b,
    input  wire logic [7:0] slvWord,
    output logic            farSclk,
    output logic            farSclkOe,
    output logic            farMosi,
    output logic            farMosiOe,
    output logic            farSel_b,
    output logic            farMiso,
    output logic [7:0]      slaveRx
);
    logic [7:0] sh;     // Slave shift register
    logic       first;  // First leading launch shows msb without a shift
    wire logic  sEff;   // Rises on the sample edge in every format
    assign sEff = sclkPin ^ cpol ^ cpha;
    // Quiet pins until a task or a select asks for them
    initial begin
        {farSclk, farSclkOe, farMosi, farMosiOe, first, sh, slaveRx} = '0;
        farSel_b = 1'h1;
        farMiso = 1'h1;
    end
    // Select by a flag output loads the word, msb out at once
    always @(negedge slvSel_b) begin
        sh = slvWord;
        first = 1'h1;
        farMiso = slvWord[7];
    end
    // Sample on one edge
    always @(posedge sEff) begin
        if (!slvSel_b) slaveRx = {slaveRx[6:0], mosiPin};
    end
    // Launch on the other; driver exists only while selected
    always @(negedge sEff) begin
        if (!slvSel_b) begin
            if (first && cpha) first = 1'h0;
            else sh = sh << 1;
            farMiso = sh[7];
        end
    end
    // Master word, mode zero; clock stands still outside the word
    task automatic mword(input logic [7:0] w, input logic sel, output logic [7:0] r);
        @(posedge lclk) farSclkOe <= 1'h1;
        farSclk <= 1'h0;
        farMosiOe <= 1'h1;
        @(posedge lclk) farSel_b <= ~sel;
        for (int i = 7; i >= 0; i--) begin
            farMosi <= w[i];
            repeat (4) @(posedge lclk);
            farSclk <= 1'h1;
            repeat (4) @(posedge lclk);
            r[i] = misoPin;
            farSclk <= 1'h0;
        end
        repeat (4) @(posedge lclk);
    endtask
    // Deselect first, then let the pull-ups take the lines
    task automatic selRelease;
        @(posedge lclk) farSel_b <= 1'h1;
        @(posedge lclk) farSclkOe <= 1'h0;
        farMosiOe <= 1'h0;
    endtask
endmodule

// *** tb/spp_port_tb.sv ***
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin fail_count++; $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module spp_port_tb;
    logic       mclk, lclk, rst_b, sPrev, watchDir, slvSel_b, errSel_b;
    logic       masterMode, clkPolarity, clkPhase, openDrainSelect, slaveOutDisable, txStart, errClear;
    logic [7:0] baudHalf, txData, slvWord, rxLast, r;
    int         fail_count, checks_done, rxCount, edgeCnt, pinBad, dirBad, n, e0;
    wire logic  sclkOut, sclkOe, mosiOut, mosiOe, misoOut, misoOe, busy, rxValid, mmErr;
    wire logic  farSclk, farSclkOe, farMosi, farMosiOe, farSel_b, farMiso;
    wire logic [7:0] rxData, slaveRx;
    // Pin levels; the pull-ups win when nobody drives
    wire logic  sclkW = sclkOe ? sclkOut : (farSclkOe ? farSclk : 1'h1);
    wire logic  mosiW = mosiOe ? mosiOut : (farMosiOe ? farMosi : 1'h1);
    wire logic  misoW = misoOe ? misoOut : (!slvSel_b ? farMiso : 1'h1);
    wire logic  selW = farSel_b & errSel_b;

    spp_port spp_port_inst (.mclk(mclk), .rst_b(rst_b), .sclkIn(sclkW), .sclkOut(sclkOut), .sclkOe(sclkOe),
        .mosiIn(mosiW), .mosiOut(mosiOut), .mosiOe(mosiOe), .misoIn(misoW), .misoOut(misoOut),
        .misoOe(misoOe), .slaveSelectIn_b(selW), .masterMode(masterMode), .clkPolarity(clkPolarity),
        .clkPhase(clkPhase), .openDrainSelect(openDrainSelect), .slaveOutDisable(slaveOutDisable),
        .baudHalf(baudHalf), .txData(txData), .txStart(txStart), .busy(busy), .rxData(rxData),
        .rxValid(rxValid), .mmErr(mmErr), .errClear(errClear));
    spp_far_model spp_far_model_inst (.lclk(lclk), .cpol(clkPolarity), .cpha(clkPhase), .sclkPin(sclkW),
        .mosiPin(mosiW), .misoPin(misoW), .slvSel_b(slvSel_b), .slvWord(slvWord), .farSclk(farSclk),
        .farSclkOe(farSclkOe), .farMosi(farMosi), .farMosiOe(farMosiOe), .farSel_b(farSel_b),
        .farMiso(farMiso), .slaveRx(slaveRx));

    // System clock and an unrelated link clock
    initial begin mclk = 1'h0; forever #5 mclk = ~mclk; end
    initial begin lclk = 1'h0; #1.7; forever #3 lclk = ~lclk; end
    // Pin watchers: clock edges, received words, driver faults
    always @(posedge mclk) begin
        sPrev <= sclkOut;
        if (sclkOe && sclkOut !== sPrev) edgeCnt <= edgeCnt + 1;
        if (rxValid) begin rxCount <= rxCount + 1; rxLast <= rxData; end
        if (misoOe && (slaveOutDisable || (openDrainSelect && misoOut))) pinBad <= pinBad + 1;
        if (watchDir && (masterMode ? misoOe : (mosiOe || sclkOe))) dirBad <= dirBad + 1;
    end
    // Let k edges pass, then look once their updates landed
    task automatic settle(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    // One master word; n counts cycles from the taking edge to rxValid
    task automatic mword(input logic [7:0] w);
        @(posedge mclk) txData <= w;
        txStart <= 1'h1;
        @(posedge mclk) txStart <= 1'h0;
        n = 0;
        do begin @(posedge mclk); #1; n++; end while (rxValid !== 1'h1 && n < 3000);
    endtask
    // Counts, verdict, end of run
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Hang guard, far beyond the several hundred cycles the tests need
    initial begin #300000; fail_count++; finish_test; end

    initial begin
        {rst_b, clkPolarity, clkPhase, openDrainSelect, slaveOutDisable, txStart, errClear, watchDir} = '0;
        {txData, slvWord} = '0;
        masterMode = 1'h1;
        errSel_b = 1'h1;
        slvSel_b = 1'h1;
        baudHalf = 8'h04;
        repeat (6) @(posedge mclk);
        rst_b <= 1'h1;
        settle(4);
        // Master words in all four formats against the far slave
        for (int m = 0; m < 4; m++) begin
            @(posedge mclk) {clkPolarity, clkPhase} <= m[1:0];
            slvWord <= 8'h3c ^ m[7:0];
            settle(4);
            @(posedge mclk) slvSel_b <= 1'h0;
            watchDir <= 1'h1;
            settle(2);
            e0 = edgeCnt;
            mword(8'ha5 ^ m[7:0]);
            `CHK("master rx", 8'h3c ^ m[7:0], rxData)
            `CHK("far rx", 8'ha5 ^ m[7:0], slaveRx)
            settle(6);
            `CHK("edges", 16, edgeCnt - e0)
            `CHK("idle clk", clkPolarity, sclkOut)
            @(posedge mclk) slvSel_b <= 1'h1;
        end
        $display("test master formats done");
        // Divider floor keeps the rate at a quarter of mclk
        @(posedge mclk) baudHalf <= 8'h01;
        {clkPolarity, clkPhase} <= 2'h0;
        settle(3);
        mword(8'h81);
        // Last toggle and the valid pulse leave the same edge: 16 half periods of 2
        `CHK("fast cycles", 32, n)
        $display("test rate floor done");
        // Select pulled low under a running master word
        @(posedge mclk) baudHalf <= 8'h04;
        txStart <= 1'h1;
        @(posedge mclk) txStart <= 1'h0;
        settle(20);
        e0 = rxCount;
        @(posedge mclk) errSel_b <= 1'h0;
        settle(6);
        `CHK("error flag", 1'h1, mmErr)
        `CHK("busy", 1'h0, busy)
        `CHK("clk drive", 1'h0, sclkOe)
        `CHK("data drive", 1'h0, mosiOe)
        @(posedge mclk) txStart <= 1'h1;
        @(posedge mclk) txStart <= 1'h0;
        settle(2);
        `CHK("refused start", 1'h0, busy)
        @(posedge mclk) errSel_b <= 1'h1;
        settle(5);
        `CHK("flag sticky", 1'h1, mmErr)
        @(posedge mclk) errClear <= 1'h1;
        @(posedge mclk) errClear <= 1'h0;
        settle(2);
        `CHK("flag cleared", 1'h0, mmErr)
        `CHK("no word", e0, rxCount)
        $display("test multimaster error done");
        // Slave role against the far master
        @(posedge mclk) masterMode <= 1'h0;
        watchDir <= 1'h0;
        txData <= 8'h96;
        settle(3);
        @(posedge mclk) watchDir <= 1'h1;
        e0 = rxCount;
        spp_far_model_inst.mword(8'h5a, 1'h1, r);
        spp_far_model_inst.mword(8'hc3, 1'h1, r);
        `CHK("slave tx", 8'h96, r)
        settle(8);
        `CHK("slave words", e0 + 2, rxCount)
        `CHK("slave rx", 8'hc3, rxLast)
        spp_far_model_inst.selRelease();
        spp_far_model_inst.mword(8'h00, 1'h0, r);
        settle(8);
        `CHK("ignored clock", e0 + 2, rxCount)
        `CHK("idle miso", 8'hff, r)
        @(posedge mclk) slaveOutDisable <= 1'h1;
        spp_far_model_inst.mword(8'h0f, 1'h1, r);
        `CHK("disabled miso", 8'hff, r)
        settle(8);
        `CHK("rx while disabled", 8'h0f, rxLast)
        @(posedge mclk) slaveOutDisable <= 1'h0;
        openDrainSelect <= 1'h1;
        spp_far_model_inst.mword(8'h33, 1'h1, r);
        `CHK("open drain miso", 7'h16, r[6:0])
        spp_far_model_inst.selRelease();
        settle(4);
        `CHK("pin faults", 0, pinBad)
        `CHK("direction faults", 0, dirBad)
        $display("test slave role done");
        finish_test;
    end
endmodule
